// file: testbench/flash_seq_sva.sv
// concurrent checks on the serial link between host end and device end
// assumes every link signal is sampled at clk_sys
`timescale 1ns/1ps
module flash_seq_sva
   import flash_seq_pkg::*;
#(
   parameter int WRITE_GAP = WRITE_CYCLES,
   parameter int ERASE_GAP = ERASE_CYCLES
) (
   // clock and reset
   input wire logic clk_sys,
   input wire logic rst,
   // link
   input wire logic sclk,
   input wire logic cs_n,
   input wire logic sdi_o,
   input wire logic sdi_oe,
   input wire logic sdo_o,
   input wire logic sdo_oe,
   input wire logic sdi,
   input wire logic sdo
);
   logic sclk_q;
   logic cs_q;
   logic drove;
   logic armed;
   logic four;
   logic [7:0] last;
   logic [4:0] pulses;
   int gap;
   int need;
   logic next_drove;
   logic next_armed;
   logic next_four;
   logic [7:0] next_last;
   logic [4:0] next_pulses;
   int next_gap;
   int next_need;
   // frame byte, clock count, modes and required gap
   always_comb begin
      next_last = last;
      next_armed = armed;
      next_four = four;
      next_need = need;
      if (!cs_n && sclk && !sclk_q) begin
         next_last = {sdi, last[7:1]};
      end
      next_pulses = cs_n ? 5'h00 : pulses + {4'h0, sclk && !sclk_q};
      next_drove = !cs_n && (drove || sdo_oe);
      next_gap = cs_n ? gap + 1 : 0;
      if (cs_n && !cs_q) begin
         next_armed = last == {M_THREE_WIRE, A_IFMODE};
         next_four = (four && !next_armed) || last == {M_FOUR_WIRE, A_IFMODE};
         next_need = (last == B_WRITE) ? WRITE_GAP : 0;
         if (last == B_PAGE_ERASE || last == B_ALL_ERASE) begin
            next_need = ERASE_GAP;
         end
      end
   end
   always_ff @(posedge clk_sys) begin
      if (rst) begin
         sclk_q <= 1'b0;
         cs_q <= 1'b1;
         drove <= 1'b0;
         armed <= 1'b0;
         four <= 1'b0;
         last <= 8'h00;
         pulses <= 5'h00;
         gap <= 0;
         need <= 0;
      end else begin
         sclk_q <= sclk;
         cs_q <= cs_n;
         drove <= next_drove;
         armed <= next_armed;
         four <= next_four;
         last <= next_last;
         pulses <= next_pulses;
         gap <= next_gap;
         need <= next_need;
      end
   end
   default clocking cb @(posedge clk_sys);
   endclocking
   default disable iff (rst);
   sequence frame_open;
      $fell(cs_n);
   endsequence
   sequence frame_close;
      $rose(cs_n);
   endsequence
   a_sclk_idle_low: assert property (cs_n |-> !sclk)
      else $error("link clock high outside a frame");
   a_do_in_frame: assert property (sdo_oe |-> !cs_n)
      else $error("output line driven outside a frame");
   a_three_arm_drive: assert property (frame_open ##0 armed |-> sdo_oe)
      else $error("output line not driven after three-wire enable");
   a_four_wire_drive: assert property (frame_open ##0 four |-> sdo_oe)
      else $error("output line not driven in four-wire mode");
   a_do_stays_off: assert property ((!cs_n && !armed && !four) |-> !sdo_oe)
      else $error("output line driven without enable");
   a_read_len: assert property (frame_close ##0 (drove && !four) |-> pulses == READ_BITS)
      else $error("three-wire read frame not sixteen clocks");
   a_byte_len: assert property (frame_close ##0 !drove |-> pulses == BYTE_BITS)
      else $error("command frame not eight clocks");
   a_di_released: assert property ((!cs_n && sdo_oe && !four) |-> !sdi_oe)
      else $error("host drives input line during three-wire read");
   a_do_steady: assert property ((!cs_n && sclk && $past(sclk)) |-> $stable(sdo_o))
      else $error("output bit changed while link clock high");
   a_write_gap: assert property (frame_open |-> gap >= need)
      else $error("frame started before program or erase time");
endmodule

// file: testbench/serial_flash_access_sequencer_tb.sv
// self-checking bench: host end and device end joined over the serial link
// assumes a 20 MHz clk_sys and shortened program and erase times
`timescale 1ns/1ps
module serial_flash_access_sequencer_tb;
   import flash_seq_pkg::*;
   localparam int WG = 50;
   localparam int EG = 200;
   logic clk_sys;
   logic rst;
   logic cmd_valid;
   logic cmd_ready;
   logic [1:0] cmd_kind;
   logic [7:0] cmd_byte;
   logic rd_valid;
   logic [15:0] rd_data;
   logic idle;
   logic [11:0] cpu_addr;
   logic [7:0] cpu_data;
   logic cpu_halted;
   logic part_sel;
   logic flash_busy;
   int miscompares;
   int cmp_count;
   flash_link_if link ();
   flash_seq_device #(.WRITE_CYC(WG), .ERASE_CYC(EG)) u_flash_seq_device (
      .link(link), .clk_sys(clk_sys), .rst(rst), .cpu_addr(cpu_addr), .cpu_data(cpu_data),
      .cpu_halted(cpu_halted), .part_sel(part_sel), .flash_busy(flash_busy));
   flash_seq_host #(.WRITE_GAP(WG), .ERASE_GAP(EG)) u_flash_seq_host (
      .link(link), .clk_sys(clk_sys), .rst(rst), .cmd_valid(cmd_valid), .cmd_ready(cmd_ready),
      .cmd_kind(cmd_kind), .cmd_byte(cmd_byte), .rd_valid(rd_valid), .rd_data(rd_data),
      .idle(idle));
   flash_seq_sva #(.WRITE_GAP(WG), .ERASE_GAP(EG)) chk_link (
      .clk_sys(clk_sys), .rst(rst), .sclk(link.sclk), .cs_n(link.cs_n), .sdi_o(link.sdi_o),
      .sdi_oe(link.sdi_oe), .sdo_o(link.sdo_o), .sdo_oe(link.sdo_oe), .sdi(link.sdi),
      .sdo(link.sdo));
   initial begin
      clk_sys = 1'b0;
      forever #25 clk_sys = ~clk_sys;
   end
   task automatic conclude();
      $display("comparisons %0d mismatches %0d", cmp_count, miscompares);
      if (miscompares == 0 && cmp_count > 0) begin
         $display("ALL CHECKS OK");
      end else begin
         $display("CHECKS NOT OK");
      end
      $finish;
   endtask
   task automatic step(inout int n);
      @(negedge clk_sys);
      n++;
      if (n > 5000) begin
         miscompares++;
         conclude();
      end
   endtask
   task automatic chk(input string what, input logic [15:0] e, input logic [15:0] g);
      cmp_count++;
      if (g !== e) begin
         miscompares++;
         $display("wrong value %s expected %h seen %h", what, e, g);
      end
   endtask
   task automatic send(input logic [1:0] k, input logic [7:0] b);
      int n;
      n = 0;
      @(negedge clk_sys);
      cmd_valid = 1'b1;
      cmd_kind = k;
      cmd_byte = b;
      while (cmd_ready !== 1'b1) step(n);
      @(negedge clk_sys);
      cmd_valid = 1'b0;
   endtask
   task automatic bt(input logic [7:0] b);
      send(K_BYTE, b);
   endtask
   task automatic cmd(input logic [3:0] c);
      bt({c, A_CMD});
   endtask
   task automatic setp(input logic [15:0] a);
      for (int i = 0; i < 4; i++) begin
         bt({a[4*i+:4], A_PTR_GRP, 2'(i)});
      end
   endtask
   task automatic wr(input logic [15:0] a, input logic [7:0] d);
      setp(a);
      bt({d[3:0], A_HOLD_GRP, 2'h0});
      bt({d[7:4], A_HOLD_GRP, 2'h1});
      cmd(C_WRITE);
   endtask
   task automatic rd(input logic [1:0] k, input logic [15:0] e);
      int n;
      n = 0;
      send(k, 8'hFF);
      while (rd_valid !== 1'b1) step(n);
      chk("read word", e, rd_data);
   endtask
   task automatic rdb(input logic [7:0] e);
      cmd(C_COPY);
      bt({M_THREE_WIRE, A_IFMODE});
      rd(K_READ3, {8'h00, e});
   endtask
   task automatic cpu(input logic [11:0] a, input logic [7:0] e);
      @(negedge clk_sys);
      cpu_addr = a;
      repeat (2) @(negedge clk_sys);
      chk("cpu_data", {8'h00, e}, {8'h00, cpu_data});
   endtask
   task automatic settle();
      int n;
      n = 0;
      while (idle !== 1'b1) step(n);
      repeat (8) @(negedge clk_sys);
      while (flash_busy !== 1'b0) step(n);
   endtask
   initial begin
      miscompares = 0;
      cmp_count = 0;
      rst = 1'b1;
      cmd_valid = 1'b0;
      cmd_kind = K_BYTE;
      cmd_byte = 8'h00;
      cpu_addr = 12'h000;
      repeat (16) @(negedge clk_sys);
      rst = 1'b0;
      chk("cpu_halted", 16'h0000, {15'h0000, cpu_halted});
      chk("part_sel", 16'h0000, {15'h0000, part_sel});
      cmd(C_HALT);
      settle();
      chk("cpu_halted", 16'h0001, {15'h0000, cpu_halted});
      cmd(C_ALL_ERASE);
      wr(16'h0000, 8'hA5);
      wr(16'h0FFF, 8'h3C);
      wr(16'h0040, 8'h12);
      settle();
      cpu(12'h000, 8'hA5);
      cpu(12'hFFF, 8'h3C);
      cpu(12'h040, 8'h12);
      setp(16'h0FFF);
      rdb(8'h3C);
      bt({4'hE, A_PTR_GRP, 2'h0});
      rdb(8'hFF);
      setp(16'hF000);
      rdb(8'hA5);
      setp(16'h0040);
      cmd(C_PAGE_ERASE);
      settle();
      cpu(12'h040, 8'hFF);
      cpu(12'h000, 8'hA5);
      cmd(C_PART);
      settle();
      chk("part_sel", 16'h0001, {15'h0000, part_sel});
      cmd(C_ALL_ERASE);
      wr(16'h007F, 8'h5A);
      settle();
      cpu(12'h000, 8'hA5);
      cpu(12'hFFF, 8'h3C);
      rdb(8'h5A);
      cmd(C_HALT);
      settle();
      chk("part_sel", 16'h0000, {15'h0000, part_sel});
      rdb(8'hFF);
      cmd(C_PAGE_ERASE);
      cmd(C_PART);
      settle();
      rdb(8'h5A);
      bt({M_FOUR_WIRE, A_IFMODE});
      rd(K_READ4, 16'h005A);
      rd(K_READ4, 16'h005A);
      wr(16'h0000, 8'h77);
      setp(16'h0040);
      cmd(C_PAGE_ERASE);
      settle();
      cmd(C_COPY);
      rd(K_READ4, 16'h00FF);
      setp(16'h0000);
      cmd(C_COPY);
      rd(K_READ4, 16'h0077);
      conclude();
   end
endmodule

// file: verilog/flash_link_if.sv
// serial command link between the host end and the device end
// assumes idle-high pull-ups for both data lines
`timescale 1ns/1ps
interface flash_link_if;
   logic sclk;
   logic cs_n;
   logic sdi_o;
   logic sdi_oe;
   logic sdo_o;
   logic sdo_oe;
   wire sdi;
   wire sdo;
   // resolved line levels, pulled high when released
   assign sdi = sdi_oe ? sdi_o : 1'b1;
   assign sdo = sdo_oe ? sdo_o : 1'b1;
   modport device (
      input sclk,
      input cs_n,
      input sdi,
      output sdo_o,
      output sdo_oe
   );
   modport host (
      output sclk,
      output cs_n,
      output sdi_o,
      output sdi_oe,
      input sdo
   );
endinterface

// file: verilog/flash_seq_device.sv
// device end: serial command decode, flash pointer/holding word, flash arrays
// assumes link.sclk only toggles while link.cs_n is low
//
// What this block does
// - write command programs pointer byte from holding byte
// - host spaces write commands by the program time
// - pointer and holding word keep nibbles between commands
// - halt command reselects program partition
// - copy loads flash byte into holding low byte
// - host halts processor before reading flash
// - change-partition command after halt selects information partition
// - three-wire enable drives holding word next frame only
// - four-wire command keeps output driven every frame
// - program partition byte addressed over 4096 bytes
// - only low twelve pointer bits address flash
// - program page or bulk erase spares information partition
// - information partition byte addressed over 128 bytes
// - information has two pages, spares program partition
// - host writes only to erased bytes
// - page erase picks page from pointer bits eleven-six, from bit six alone in information partition
// - non-flash commands finish within eight master clocks
`timescale 1ns/1ps
module flash_seq_device
   import flash_seq_pkg::*;
#(
   parameter int WRITE_CYC = WRITE_CYCLES,
   parameter int ERASE_CYC = ERASE_CYCLES
) (
   // link
   flash_link_if.device link,
   // clock and reset
   input wire logic clk_sys,
   input wire logic rst,
   // processor fetch port
   input wire logic [11:0] cpu_addr,
   output logic [7:0] cpu_data,
   // status
   output logic cpu_halted,
   output logic part_sel,
   output logic flash_busy
);
   if (WRITE_CYC < 1 || ERASE_CYC < 1 || ERASE_CYC >= 2 ** BUSY_BITS) begin : g_bad
      $error("flash_seq_device: busy counts out of range");
   end

   // link clock domain
   logic [7:0] shift_in;
   logic [7:0] next_shift_in;
   logic [3:0] out_idx;
   logic [3:0] next_out_idx;

   // master clock domain
   logic cs_s1, cs_s2, cs_s3;
   logic [15:0] data_holding_register, next_data_holding_register;
   logic [15:0] flash_address_pointer, next_ptr;
   logic halted, next_halted;
   logic part, next_part;
   logic four_wire, next_four_wire;
   logic three_armed, next_three_armed;
   logic [BUSY_BITS-1:0] busy_cnt, next_busy_cnt;
   logic wr_en, perase_en, aerase_en;
   logic cs_rise;
   logic [3:0] nib_addr, nib_data;
   logic [7:0] rd_byte;
   logic [7:0] mem0 [P0_BYTES];
   logic [7:0] next_mem0 [P0_BYTES];
   logic [7:0] mem1 [P1_BYTES];
   logic [7:0] next_mem1 [P1_BYTES];
   logic [7:0] next_cpu_data;

   // input shift, first bit lands in bit 0 after eight clocks
   always_comb begin
      next_shift_in = link.cs_n ? shift_in : {link.sdi, shift_in[7:1]};
   end

   always_ff @(posedge link.sclk) begin
      shift_in <= next_shift_in;
   end

   // output bit index, cleared by the frame's own select
   always_comb begin
      next_out_idx = out_idx + 4'h1;
   end

   always_ff @(negedge link.sclk or posedge link.cs_n) begin
      if (link.cs_n) begin
         out_idx <= 4'h0;
      end else begin
         out_idx <= next_out_idx;
      end
   end

   // msb first, changes at falling edges
   assign link.sdo_o = data_holding_register[~out_idx];
   assign link.sdo_oe = ~link.cs_n & (four_wire | three_armed);

   // select crossing into master clock
   always_ff @(posedge clk_sys) begin
      if (rst) begin
         cs_s1 <= 1'b1;
         cs_s2 <= 1'b1;
         cs_s3 <= 1'b1;
      end else begin
         cs_s1 <= link.cs_n;
         cs_s2 <= cs_s1;
         cs_s3 <= cs_s2;
      end
   end

   // shift_in is still since sclk stopped with the select
   assign cs_rise = cs_s2 & ~cs_s3;
   assign nib_addr = shift_in[3:0];
   assign nib_data = shift_in[7:4];
   assign rd_byte = part ? mem1[flash_address_pointer[P1_ADDR_BITS-1:0]]
                         : mem0[flash_address_pointer[P0_ADDR_BITS-1:0]];

   // command decode, done two to three clocks after select rises
   always_comb begin
      next_data_holding_register = data_holding_register;
      next_ptr = flash_address_pointer;
      next_halted = halted;
      next_part = part;
      next_four_wire = four_wire;
      next_three_armed = three_armed;
      next_busy_cnt = busy_cnt;
      wr_en = 1'b0;
      perase_en = 1'b0;
      aerase_en = 1'b0;
      if (busy_cnt != '0) begin
         next_busy_cnt = busy_cnt - BUSY_BITS'(1);
      end
      if (cs_rise) begin
         next_three_armed = 1'b0;
         if (nib_addr[3:2] == A_HOLD_GRP) begin
            next_data_holding_register[{nib_addr[1:0], 2'b00} +: 4] = nib_data;
         end else if (nib_addr[3:2] == A_PTR_GRP) begin
            next_ptr[{nib_addr[1:0], 2'b00} +: 4] = nib_data;
         end else if (nib_addr == A_CMD) begin
            case (nib_data)
               C_HALT: begin
                  next_halted = 1'b1;
                  next_part = 1'b0;
               end
               C_PART: begin
                  if (halted) begin
                     next_part = 1'b1;
                  end
               end
               C_COPY: begin
                  next_data_holding_register = {8'h00, rd_byte};
               end
               C_WRITE: begin
                  if (halted && busy_cnt == '0) begin
                     wr_en = 1'b1;
                     next_busy_cnt = BUSY_BITS'(WRITE_CYC);
                  end
               end
               C_PAGE_ERASE: begin
                  if (halted && busy_cnt == '0) begin
                     perase_en = 1'b1;
                     next_busy_cnt = BUSY_BITS'(ERASE_CYC);
                  end
               end
               C_ALL_ERASE: begin
                  if (halted && busy_cnt == '0) begin
                     aerase_en = 1'b1;
                     next_busy_cnt = BUSY_BITS'(ERASE_CYC);
                  end
               end
               default: begin
               end
            endcase
         end else if (nib_addr == A_IFMODE) begin
            case (nib_data)
               M_FOUR_WIRE: begin
                  next_four_wire = 1'b1;
               end
               M_THREE_WIRE: begin
                  next_four_wire = 1'b0;
                  next_three_armed = 1'b1;
               end
               default: begin
               end
            endcase
         end
      end
   end

   always_ff @(posedge clk_sys) begin
      if (rst) begin
         data_holding_register <= 16'h0000;
         flash_address_pointer <= 16'h0000;
         halted <= 1'b0;
         part <= 1'b0;
         four_wire <= 1'b0;
         three_armed <= 1'b0;
         busy_cnt <= '0;
      end else begin
         data_holding_register <= next_data_holding_register;
         flash_address_pointer <= next_ptr;
         halted <= next_halted;
         part <= next_part;
         four_wire <= next_four_wire;
         three_armed <= next_three_armed;
         busy_cnt <= next_busy_cnt;
      end
   end

   // program partition array, programming only clears bits
   for (genvar i = 0; i < P0_BYTES; i++) begin : g_p0
      always_comb begin
         next_mem0[i] = mem0[i];
         if (!part && flash_address_pointer[P0_ADDR_BITS-1:0] == P0_ADDR_BITS'(i)) begin
            if (wr_en) begin
               next_mem0[i] = mem0[i] & data_holding_register[7:0];
            end
         end
         if (!part && (aerase_en || (perase_en &&
             flash_address_pointer[P0_ADDR_BITS-1:PAGE_LSB] ==
             (P0_ADDR_BITS-PAGE_LSB)'(i / PAGE_BYTES)))) begin
            next_mem0[i] = ERASED;
         end
      end
      always_ff @(posedge clk_sys) begin
         mem0[i] <= next_mem0[i];
      end
   end

   // information partition array
   for (genvar j = 0; j < P1_BYTES; j++) begin : g_p1
      always_comb begin
         next_mem1[j] = mem1[j];
         if (part && wr_en &&
             flash_address_pointer[P1_ADDR_BITS-1:0] == P1_ADDR_BITS'(j)) begin
            next_mem1[j] = mem1[j] & data_holding_register[7:0];
         end
         if (part && (aerase_en || (perase_en &&
             flash_address_pointer[PAGE_LSB] == 1'(j / PAGE_BYTES)))) begin
            next_mem1[j] = ERASED;
         end
      end
      always_ff @(posedge clk_sys) begin
         mem1[j] <= next_mem1[j];
      end
   end

   // processor fetch, program partition only
   always_comb begin
      next_cpu_data = mem0[cpu_addr];
   end

   always_ff @(posedge clk_sys) begin
      if (rst) begin
         cpu_data <= 8'h00;
      end else begin
         cpu_data <= next_cpu_data;
      end
   end

   assign cpu_halted = halted;
   assign part_sel = part;
   assign flash_busy = (busy_cnt != '0);
endmodule

// file: verilog/flash_seq_host.sv
// host end: frame queue and serial frame generator with divided link clock
// assumes the device end answers as the shared package describes
`timescale 1ns/1ps
module fifo_buf #(
   parameter int WIDTH = 10,
   parameter int DEPTH = 8
) (
   input wire logic clk_sys,
   input wire logic rst,
   // fill side
   input wire logic in_valid,
   output logic in_ready,
   input wire logic [WIDTH-1:0] in_data,
   // drain side
   output logic out_valid,
   input wire logic out_ready,
   output logic [WIDTH-1:0] out_data
);
   localparam int AW = $clog2(DEPTH);
   if (DEPTH < 2 || (1 << AW) != DEPTH || WIDTH < 1) begin : g_bad
      $error("fifo_buf: depth must be a power of two");
   end
   logic [WIDTH-1:0] store [DEPTH];
   logic [AW:0] wr_ptr, next_wr_ptr, rd_ptr, next_rd_ptr;
   logic push, pop;

   assign in_ready = (wr_ptr - rd_ptr) != (AW+1)'(DEPTH);
   assign out_valid = wr_ptr != rd_ptr;
   assign out_data = store[rd_ptr[AW-1:0]];
   assign push = in_valid & in_ready;
   assign pop = out_valid & out_ready;

   always_comb begin
      next_wr_ptr = wr_ptr + (AW+1)'(push);
      next_rd_ptr = rd_ptr + (AW+1)'(pop);
   end

   always_ff @(posedge clk_sys) begin
      if (rst) begin
         wr_ptr <= '0;
         rd_ptr <= '0;
      end else begin
         wr_ptr <= next_wr_ptr;
         rd_ptr <= next_rd_ptr;
      end
   end

   always_ff @(posedge clk_sys) begin
      if (push) begin
         store[wr_ptr[AW-1:0]] <= in_data;
      end
   end
endmodule

module flash_seq_host
   import flash_seq_pkg::*;
#(
   parameter int HALF = SCLK_HALF,
   parameter int WRITE_GAP = WRITE_CYCLES,
   parameter int ERASE_GAP = ERASE_CYCLES
) (
   // link
   flash_link_if.host link,
   // clock and reset
   input wire logic clk_sys,
   input wire logic rst,
   // frame requests
   input wire logic cmd_valid,
   output logic cmd_ready,
   input wire logic [1:0] cmd_kind,
   input wire logic [7:0] cmd_byte,
   // read results
   output logic rd_valid,
   output logic [15:0] rd_data,
   output logic idle
);
   if (HALF < 3 || HALF > 255 || WRITE_GAP < 1 || ERASE_GAP >= 2 ** BUSY_BITS) begin : g_bad
      $error("flash_seq_host: timing parameters out of range");
   end

   typedef enum logic [2:0] {
      H_IDLE = 3'b000,
      H_LOW = 3'b001,
      H_HIGH = 3'b010,
      H_END = 3'b011,
      H_GAP = 3'b100
   } host_state_e;

   host_state_e state, next_state;
   logic f_valid, f_ready;
   logic [9:0] f_data;
   logic [7:0] div, next_div;
   logic [4:0] bitn, next_bitn, nbits, next_nbits;
   logic [15:0] tx, next_tx, rx, next_rx, next_rd_data;
   logic [7:0] cur, next_cur;
   frame_kind_e kind, next_kind;
   logic sclk_q, next_sclk, cs_q, next_cs, di_q, next_di, oe_q, next_oe;
   logic next_rd_valid;
   logic [BUSY_BITS-1:0] gap, next_gap;
   logic sdo_s1, sdo_s2;

   fifo_buf #(.WIDTH(10), .DEPTH(8)) u_fifo (
      .clk_sys(clk_sys),
      .rst(rst),
      .in_valid(cmd_valid),
      .in_ready(cmd_ready),
      .in_data({cmd_kind, cmd_byte}),
      .out_valid(f_valid),
      .out_ready(f_ready),
      .out_data(f_data)
   );

   assign f_ready = (state == H_IDLE);
   assign link.sclk = sclk_q;
   assign link.cs_n = cs_q;
   assign link.sdi_o = di_q;
   assign link.sdi_oe = oe_q;
   assign idle = (state == H_IDLE) & ~f_valid;

   // data line from the device
   always_ff @(posedge clk_sys) begin
      if (rst) begin
         sdo_s1 <= 1'b1;
         sdo_s2 <= 1'b1;
      end else begin
         sdo_s1 <= link.sdo;
         sdo_s2 <= sdo_s1;
      end
   end

   always_comb begin
      next_state = state;
      next_div = div;
      next_bitn = bitn;
      next_nbits = nbits;
      next_tx = tx;
      next_rx = rx;
      next_cur = cur;
      next_kind = kind;
      next_sclk = sclk_q;
      next_cs = cs_q;
      next_di = di_q;
      next_oe = oe_q;
      next_gap = gap;
      next_rd_valid = 1'b0;
      next_rd_data = rd_data;
      case (state)
         H_IDLE: begin
            if (f_valid) begin
               next_kind = frame_kind_e'(f_data[9:8]);
               next_cur = f_data[7:0];
               next_tx = (f_data[9:8] == K_READ4) ? {f_data[7:0], 8'h00}
                                                  : {8'h00, f_data[7:0]};
               next_nbits = (f_data[9:8] == K_BYTE) ? BYTE_BITS : READ_BITS;
               next_di = (f_data[9:8] == K_READ4) ? 1'b0 : f_data[0];
               next_oe = (f_data[9:8] != K_READ3);
               next_cs = 1'b0;
               next_div = 8'h00;
               next_bitn = 5'h00;
               next_state = H_LOW;
            end
         end
         H_LOW: begin
            next_div = div + 8'h01;
            if (div == 8'(HALF - 1)) begin
               next_div = 8'h00;
               next_sclk = 1'b1;
               next_rx = {rx[14:0], sdo_s2};
               next_state = H_HIGH;
            end
         end
         H_HIGH: begin
            next_div = div + 8'h01;
            if (div == 8'(HALF - 1)) begin
               next_div = 8'h00;
               next_sclk = 1'b0;
               if (bitn == nbits - 5'h01) begin
                  next_state = H_END;
               end else begin
                  next_bitn = bitn + 5'h01;
                  next_tx = {1'b0, tx[15:1]};
                  next_di = tx[1];
                  next_state = H_LOW;
               end
            end
         end
         H_END: begin
            next_div = div + 8'h01;
            if (div == 8'(HALF - 1)) begin
               next_cs = 1'b1;
               next_oe = 1'b0;
               if (kind != K_BYTE) begin
                  next_rd_valid = 1'b1;
                  next_rd_data = rx;
               end
               if (kind == K_BYTE && cur == B_WRITE) begin
                  next_gap = BUSY_BITS'(WRITE_GAP);
               end else if (kind == K_BYTE && (cur == B_PAGE_ERASE || cur == B_ALL_ERASE)) begin
                  next_gap = BUSY_BITS'(ERASE_GAP);
               end else begin
                  next_gap = BUSY_BITS'(FRAME_GAP);
               end
               next_state = H_GAP;
            end
         end
         H_GAP: begin
            next_gap = gap - BUSY_BITS'(1);
            if (gap <= BUSY_BITS'(1)) begin
               next_state = H_IDLE;
            end
         end
         default: begin
            next_state = H_IDLE;
         end
      endcase
   end

   always_ff @(posedge clk_sys) begin
      if (rst) begin
         state <= H_IDLE;
         div <= 8'h00;
         bitn <= 5'h00;
         nbits <= BYTE_BITS;
         tx <= 16'h0000;
         rx <= 16'h0000;
         cur <= 8'h00;
         kind <= K_BYTE;
         sclk_q <= 1'b0;
         cs_q <= 1'b1;
         di_q <= 1'b0;
         oe_q <= 1'b0;
         gap <= '0;
         rd_valid <= 1'b0;
         rd_data <= 16'h0000;
      end else begin
         state <= next_state;
         div <= next_div;
         bitn <= next_bitn;
         nbits <= next_nbits;
         tx <= next_tx;
         rx <= next_rx;
         cur <= next_cur;
         kind <= next_kind;
         sclk_q <= next_sclk;
         cs_q <= next_cs;
         di_q <= next_di;
         oe_q <= next_oe;
         gap <= next_gap;
         rd_valid <= next_rd_valid;
         rd_data <= next_rd_data;
      end
   end
endmodule

// file: verilog/flash_seq_pkg.sv
// constants shared by the flash access device end and the host end
// assumes both ends run their master clock at the rate given here
package flash_seq_pkg;
   // timing
   localparam int CLK_PERIOD_NS = 50;
   localparam int WRITE_TIME_NS = 80000;
   localparam int ERASE_TIME_NS = 4200000;
   localparam int WRITE_CYCLES = (WRITE_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int ERASE_CYCLES = (ERASE_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int CMD_DONE_CYCLES = 8;
   localparam int SCLK_HALF = 4;
   localparam int FRAME_GAP = 2 * CMD_DONE_CYCLES;
   localparam int BUSY_BITS = 20;
   // flash geometry
   localparam int P0_BYTES = 4096;
   localparam int P1_BYTES = 128;
   localparam int PAGE_BYTES = 64;
   localparam int P0_ADDR_BITS = 12;
   localparam int P1_ADDR_BITS = 7;
   localparam int PAGE_LSB = 6;
   localparam logic [7:0] ERASED = 8'hFF;
   // serial word: address nibble low, data nibble high
   localparam logic [1:0] A_HOLD_GRP = 2'h0;
   localparam logic [1:0] A_PTR_GRP = 2'h1;
   localparam logic [3:0] A_CMD = 4'h8;
   localparam logic [3:0] A_IFMODE = 4'h9;
   // command nibbles
   localparam logic [3:0] C_WRITE = 4'h1;
   localparam logic [3:0] C_COPY = 4'h3;
   localparam logic [3:0] C_HALT = 4'h7;
   localparam logic [3:0] C_PAGE_ERASE = 4'hD;
   localparam logic [3:0] C_ALL_ERASE = 4'hE;
   localparam logic [3:0] C_PART = 4'hF;
   localparam logic [3:0] M_FOUR_WIRE = 4'h0;
   localparam logic [3:0] M_THREE_WIRE = 4'h1;
   // whole bytes the host watches for
   localparam logic [7:0] B_WRITE = 8'h18;
   localparam logic [7:0] B_PAGE_ERASE = 8'hD8;
   localparam logic [7:0] B_ALL_ERASE = 8'hE8;
   localparam logic [4:0] BYTE_BITS = 5'h08;
   localparam logic [4:0] READ_BITS = 5'h10;
   localparam logic [7:0] PULL_LEVEL = 8'h01;
   // host frame kinds
   typedef enum logic [1:0] {
      K_BYTE = 2'b00,
      K_READ3 = 2'b01,
      K_READ4 = 2'b10
   } frame_kind_e;
endpackage
